// >>> rtl/cmis_cfg.svh
// constants for the cache maintenance issue sequencer
`ifndef CMIS_CFG_SVH
`define CMIS_CFG_SVH

// ===========================================================
// snoop-type codes on the read address channel
`define CMIS_SNP_CLEAN_KEEP   4'h8
`define CMIS_SNP_CLEAN_DROP   4'h9
`define CMIS_SNP_DROP_NOWRITE 4'hd

// ===========================================================
// shareability codes
`define CMIS_DOM_NONSH  2'h0
`define CMIS_DOM_INNER  2'h1
`define CMIS_DOM_OUTER  2'h2
`define CMIS_DOM_SYSTEM 2'h3

// ===========================================================
// cacheability attribute values
`define CMIS_CACHE_NORMAL_NC 4'h2
`define CMIS_CACHE_WB_ALLOC  4'hf

// ===========================================================
// line geometry: 64-byte line on a 16-byte data bus
`define CMIS_LINE_MASK 32'hffff_ffc0
`define CMIS_LINE_LEN  8'h03
`define CMIS_LINE_SIZE 3'h4

`endif

// >>> rtl/cmis_pkg.sv
// types for the cache maintenance issue sequencer
package cmis_pkg;

  // ===========================================================
  // maintenance kinds requested by the local cache controller
  typedef enum logic [1:0] {
    CMIS_OP_CLEAN_KEEP   = 2'h0,
    CMIS_OP_CLEAN_DROP   = 2'h1,
    CMIS_OP_DROP_NOWRITE = 2'h2
  } cmis_op_t;

  // ===========================================================
  // request from the local cache controller
  typedef struct packed {
    logic [31:0] addr;
    cmis_op_t    op;
    logic        cacheable;
    logic [1:0]  domain;
    logic        devAllCaches;
  } cmis_req_t;

  // ===========================================================
  // read address beat of a maintenance operation
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  readSnoopType;
    logic [3:0]  cacheabilityAttr;
    logic [1:0]  shareabilityAttr;
    logic [7:0]  len;
    logic [2:0]  size;
  } cmis_ar_t;

  // ===========================================================
  // dirty-line write request to the local write path
  typedef struct packed {
    logic [31:0] addr;
    logic        evict;
  } cmis_wb_t;

endpackage : cmis_pkg

// >>> rtl/cmis_sequencer.sv
// broadcast maintenance operation sequencer with handover phase tracking
`timescale 1ns/1ps
`default_nettype none
`include "cmis_cfg.svh"

// Operation
// - operations use read address channel with snoop codes 8, 9, d
// - wait for outstanding allocating shareable transactions to the line
// - dirty line gets write-back or write-clean completed before clean operations
// - clean line with outstanding cacheable traffic must not end dirty
// - invalidate local copy before clean-and-drop or drop operations
// - issue only after all required transactions and writes completed
// - evicts and local unique writes stay allowed during clean-keep sequence
// - block new allocating shareable transactions to line until sequence ends
// - writes and responses let an external snoop filter track allocation
// - attributes select caches; device all-cache instructions go outer shareable
// - handover runs access, clean, agent access, invalidate, access in order
// - coherent access only phases 1 and 5, agent only phase 3
// - every operation covers exactly one full cache line
// - domain never system shareable, so operation is always normal memory
module cmis_sequencer
  import cmis_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  input  wire logic      cmoEnable,
  input  wire logic      reqValid,
  output logic           reqReady,
  input  wire cmis_req_t req,
  output logic [31:0]    lineAddr,
  input  wire logic      lineDirty,
  input  wire logic      pendAlloc,
  input  wire logic      pendCacheable,
  output logic           blockAlloc,
  output logic           wbValid,
  input  wire logic      wbReady,
  output cmis_wb_t       wb,
  input  wire logic      wbDone,
  output logic           invValid,
  input  wire logic      invReady,
  input  wire logic      invDone,
  output logic           arValid,
  input  wire logic      arReady,
  output cmis_ar_t       ar,
  input  wire logic      rValid,
  output logic           rReady,
  input  wire logic [1:0] rResp,
  input  wire logic      rLast,
  output logic           doneValid,
  output logic [1:0]     doneResp,
  output logic           doneLocal,
  input  wire logic      hoStep,
  output logic [4:0]     hoPhase,
  output logic           coherentOk,
  output logic           agentOk
);

  // ===========================================================
  // state encodings
  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_DRAIN   = 8'h02,
    S_WBREQ   = 8'h04,
    S_WBWAIT  = 8'h08,
    S_INVREQ  = 8'h10,
    S_INVWAIT = 8'h20,
    S_ISSUE   = 8'h40,
    S_RESP    = 8'h80
  } cmis_state_t;

  typedef enum logic [4:0] {
    P_COH1   = 5'h01,
    P_CLEAN  = 5'h02,
    P_AGENT  = 5'h04,
    P_INVAL  = 5'h08,
    P_COH5   = 5'h10
  } cmis_phase_t;

  // ===========================================================
  // reset release and enable synchroniser
  logic        rstMeta_r;
  logic        rstSyncN_r;
  logic        enMeta_r;
  logic        enSync_r;

  // release through two flops so every other flop leaves reset together
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r  <= 1'b0;
      rstSyncN_r <= 1'b0;
    end else begin
      rstMeta_r  <= 1'b1;
      rstSyncN_r <= rstMeta_r;
    end
  end

  // enable is a strap from outside the clock domain
  always_ff @(posedge sys_clk or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      enMeta_r <= 1'b0;
      enSync_r <= 1'b0;
    end else begin
      enMeta_r <= cmoEnable;
      enSync_r <= enMeta_r;
    end
  end

  // ===========================================================
  // registers
  cmis_state_t state_r;
  cmis_state_t state_nxt;
  cmis_phase_t phase_r;
  cmis_phase_t phase_nxt;
  cmis_op_t    op_r;
  cmis_ar_t    ar_r;
  logic [31:0] addr_r;
  logic        doneValid_r;
  logic [1:0]  doneResp_r;
  logic        doneLocal_r;

  // ===========================================================
  // request decode
  wire logic       idle      = (state_r == S_IDLE);
  wire logic       opClean   = (req.op != CMIS_OP_DROP_NOWRITE);
  wire logic       opInval   = (req.op != CMIS_OP_CLEAN_KEEP);
  wire logic       phaseOk   = (phase_r == P_COH1) |
                               (phase_r == P_COH5) |
                               ((phase_r == P_CLEAN) & opClean) |
                               ((phase_r == P_INVAL) & opInval);
  wire logic       reqTake   = reqValid & reqReady;
  wire logic [31:0] alignAddr = req.addr & `CMIS_LINE_MASK;

  // operation kind to snoop-type code
  wire logic [3:0] snpCode =
    (req.op == CMIS_OP_CLEAN_KEEP) ? `CMIS_SNP_CLEAN_KEEP :
    (req.op == CMIS_OP_CLEAN_DROP) ? `CMIS_SNP_CLEAN_DROP :
                                     `CMIS_SNP_DROP_NOWRITE;

  // device memory that must reach every cache widens to outer shareable
  wire logic [1:0] domFix =
    req.devAllCaches              ? `CMIS_DOM_OUTER :
    (req.domain == `CMIS_DOM_SYSTEM) ? `CMIS_DOM_OUTER :
                                    req.domain;

  // cacheability is always normal memory, never device
  wire logic [3:0] cacheFix =
    (req.cacheable | req.devAllCaches) ? `CMIS_CACHE_WB_ALLOC :
                                         `CMIS_CACHE_NORMAL_NC;

  // the op register follows the sequence after capture
  wire logic opCleanR = (op_r != CMIS_OP_DROP_NOWRITE);
  wire logic opInvalR = (op_r != CMIS_OP_CLEAN_KEEP);

  // ===========================================================
  // handshake outputs
  assign reqReady   = idle & phaseOk & rstSyncN_r;
  assign wbValid    = (state_r == S_WBREQ);
  assign invValid   = (state_r == S_INVREQ);
  assign arValid    = (state_r == S_ISSUE);
  assign rReady     = (state_r == S_RESP);
  // new allocating traffic to this line waits while busy; evicts and
  // local writes to a unique line are not gated by this block
  assign blockAlloc = ~idle;
  assign lineAddr   = addr_r;
  assign ar         = ar_r;
  // retain copy for clean-keep, evict for clean-and-drop
  assign wb.addr    = addr_r;
  assign wb.evict   = opInvalR;
  assign doneValid  = doneValid_r;
  assign doneResp   = doneResp_r;
  assign doneLocal  = doneLocal_r;
  assign hoPhase    = phase_r;
  assign coherentOk = (phase_r == P_COH1) | (phase_r == P_COH5);
  assign agentOk    = (phase_r == P_AGENT);

  // ===========================================================
  // sequence steps
  wire logic drained  = ~pendAlloc & ~pendCacheable;
  wire logic needWb   = opCleanR & lineDirty;
  wire logic needInv  = opInvalR;
  wire logic lastBeat = rValid & rLast;

  // main sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (reqTake) begin
          state_nxt = S_DRAIN;
        end
      end
      // dirtiness is sampled only after outstanding traffic settles
      S_DRAIN: begin
        if (drained) begin
          if (needWb) begin
            state_nxt = S_WBREQ;
          end else if (needInv) begin
            state_nxt = S_INVREQ;
          end else begin
            state_nxt = enSync_r ? S_ISSUE : S_IDLE;
          end
        end
      end
      S_WBREQ: begin
        if (wbReady) begin
          state_nxt = S_WBWAIT;
        end
      end
      S_WBWAIT: begin
        if (wbDone) begin
          if (needInv) begin
            state_nxt = S_INVREQ;
          end else begin
            state_nxt = enSync_r ? S_ISSUE : S_IDLE;
          end
        end
      end
      S_INVREQ: begin
        if (invReady) begin
          state_nxt = S_INVWAIT;
        end
      end
      S_INVWAIT: begin
        if (invDone) begin
          state_nxt = enSync_r ? S_ISSUE : S_IDLE;
        end
      end
      S_ISSUE: begin
        if (arReady) begin
          state_nxt = S_RESP;
        end
      end
      // the beat marked last closes the operation
      S_RESP: begin
        if (lastBeat) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // local finish without a bus beat when issuing is off
  wire logic finLocal = ~enSync_r & (state_nxt == S_IDLE) &
                        (state_r != S_IDLE) & (state_r != S_RESP);
  wire logic finBus   = (state_r == S_RESP) & lastBeat;

  // ===========================================================
  // handover phases; clean and invalidate phases end only when idle
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      P_COH1:  phase_nxt = hoStep ? P_CLEAN : P_COH1;
      P_CLEAN: phase_nxt = (hoStep & idle) ? P_AGENT : P_CLEAN;
      P_AGENT: phase_nxt = hoStep ? P_INVAL : P_AGENT;
      P_INVAL: phase_nxt = (hoStep & idle) ? P_COH5 : P_INVAL;
      P_COH5:  phase_nxt = hoStep ? P_COH1 : P_COH5;
      default: phase_nxt = P_COH1;
    endcase
  end

  // ===========================================================
  // state and phase registers
  always_ff @(posedge sys_clk or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      state_r <= S_IDLE;
      phase_r <= P_COH1;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ===========================================================
  // capture of the line and its bus beat
  always_ff @(posedge sys_clk or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      addr_r <= 32'h0000_0000;
      op_r   <= CMIS_OP_CLEAN_KEEP;
      ar_r   <= '0;
    end else if (reqTake) begin
      addr_r                <= alignAddr;
      op_r                  <= req.op;
      ar_r.addr             <= alignAddr;
      ar_r.readSnoopType    <= snpCode;
      ar_r.cacheabilityAttr <= cacheFix;
      ar_r.shareabilityAttr <= domFix;
      ar_r.len              <= `CMIS_LINE_LEN;
      ar_r.size             <= `CMIS_LINE_SIZE;
    end
  end

  // ===========================================================
  // completion pulse; the response code is kept until next finish
  always_ff @(posedge sys_clk or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      doneValid_r <= 1'b0;
      doneResp_r  <= 2'h0;
      doneLocal_r <= 1'b0;
    end else begin
      doneValid_r <= finLocal | finBus;
      if (finBus) begin
        doneResp_r  <= rResp;
        doneLocal_r <= 1'b0;
      end else if (finLocal) begin
        doneResp_r  <= 2'h0;
        doneLocal_r <= 1'b1;
      end
    end
  end

endmodule : cmis_sequencer

`default_nettype wire

// >>> verification/cmis_sequencer_asserts.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "cmis_cfg.svh"
module cmis_sequencer_asserts
  import cmis_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       cmoEnable,
  input wire logic       pendAlloc,
  input wire logic       blockAlloc,
  input wire logic       wbValid,
  input wire logic       invValid,
  input wire logic       invReady,
  input wire logic       arValid,
  input wire logic       arReady,
  input wire cmis_ar_t   ar,
  input wire logic       rValid,
  input wire logic       rReady,
  input wire logic       rLast,
  input wire logic       doneValid,
  input wire logic [4:0] hoPhase,
  input wire logic       coherentOk,
  input wire logic       agentOk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // local drop seen since the last completion
  logic invSeen_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) invSeen_r <= 1'h0;
    else if (doneValid) invSeen_r <= 1'h0;
    else if (invValid && invReady) invSeen_r <= 1'h1;
  end
  // ==========================================================
  // bus request shape and timing
  AST_SNP_CODE: assert property (arValid |->
    ar.readSnoopType inside
    {`CMIS_SNP_CLEAN_KEEP, `CMIS_SNP_CLEAN_DROP, `CMIS_SNP_DROP_NOWRITE})
    else $error("snoop code outside the maintenance set");
  AST_ONE_LINE: assert property (arValid |->
    ar.addr[5:0] == 6'h0 && ar.len == `CMIS_LINE_LEN &&
    ar.size == `CMIS_LINE_SIZE) else $error("request is not one whole line");
  AST_NO_SYS: assert property (arValid |->
    ar.shareabilityAttr != `CMIS_DOM_SYSTEM) else $error("system domain");
  AST_AR_HOLD: assert property (arValid && !arReady |=>
    arValid && $stable(ar)) else $error("request dropped before ready");
  AST_NO_PEND: assert property ((arValid || wbValid) |->
    !pendAlloc) else $error("issued with allocating traffic pending");
  AST_INV_FIRST: assert property (arValid &&
    ar.readSnoopType != `CMIS_SNP_CLEAN_KEEP |-> invSeen_r)
    else $error("bus drop before local drop");
  AST_BLOCK: assert property (
    (arValid || wbValid || invValid || rReady) |-> blockAlloc)
    else $error("allocation not blocked");
  AST_DONE: assert property (rValid && rReady && rLast |=>
    doneValid && !blockAlloc) else $error("no completion after beat");
  AST_EN: assert property ($rose(arValid) |-> cmoEnable)
    else $error("bus request while disabled");
  AST_PHASE: assert property (
    coherentOk == (hoPhase[0] || hoPhase[4]) && agentOk == hoPhase[2])
    else $error("access grant wrong for phase");
  // the last phase steps back to the first, which a plain shift misses
  AST_PH_STEP: assert property (!$stable(hoPhase) |->
    hoPhase == ($past(hoPhase) << 1) ||
    ($past(hoPhase) == 5'h10 && hoPhase == 5'h01))
    else $error("phase skipped");
endmodule : cmis_sequencer_asserts

bind cmis_sequencer cmis_sequencer_asserts u_chk (.sys_clk, .nrst,
  .cmoEnable, .pendAlloc, .blockAlloc, .wbValid, .invValid, .invReady,
  .arValid, .arReady, .ar, .rValid, .rReady, .rLast, .doneValid,
  .hoPhase, .coherentOk, .agentOk);
`default_nettype wire

// >>> verification/cmis_ic_model.sv
// behavioural interconnect and write path answering the sequencer
`timescale 1ns/1ps
`default_nettype none
module cmis_ic_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic arValid,
  output logic      arReady,
  output logic      rValid,
  input  wire logic rReady,
  output logic [1:0] rResp,
  output logic      rLast,
  input  wire logic wbValid,
  output logic      wbReady,
  output logic      wbDone,
  input  wire logic invValid,
  output logic      invReady,
  output logic      invDone
);
  logic [1:0] cnt_r;
  logic       pend_r;
  logic       go;
  // slow mode answers one cycle in four to stretch the ready and read-beat waits; done pulses still follow one cycle later
  assign go       = !slow || cnt_r == 2'h3;
  assign arReady  = arValid && go;
  assign wbReady  = wbValid && go;
  assign invReady = invValid && go;
  // single beat only once the request is held and settled downstream
  assign rValid   = pend_r && go;
  assign rLast    = rValid;
  // idle response lines wander so stale values cannot pass
  assign rResp    = rValid ? 2'h0 : cnt_r;
  // ==========================================================
  // completion pulses and the forwarded operation in flight
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r   <= 2'h0;
      pend_r  <= 1'h0;
      wbDone  <= 1'h0;
      invDone <= 1'h0;
    end else begin
      cnt_r   <= cnt_r + 2'h1;
      wbDone  <= wbValid && wbReady;
      invDone <= invValid && invReady;
      if (arValid && arReady) pend_r <= 1'h1;
      else if (rValid && rReady) pend_r <= 1'h0;
    end
  end
endmodule : cmis_ic_model
`default_nettype wire

// >>> verification/tb_cache_maintenance_issue_sequencer.sv
// self-checking bench for the maintenance sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cmis_cfg.svh"
module tb_cache_maintenance_issue_sequencer import cmis_pkg::*;;
  logic sys_clk, nrst, cmoEnable, reqValid, reqReady, lineDirty;
  logic pendAlloc, pendCacheable, blockAlloc, wbValid, wbReady, wbDone;
  logic invValid, invReady, invDone, arValid, arReady, rValid, rReady;
  logic rLast, doneValid, doneLocal, hoStep, coherentOk, agentOk, slow;
  logic [31:0] lineAddr;
  logic [1:0]  rResp, doneResp;
  logic [4:0]  hoPhase;
  cmis_req_t   req;
  cmis_wb_t    wb;
  cmis_ar_t    ar;
  int          bad_count, num_checks, cyc;

  cmis_sequencer dut (.sys_clk, .nrst, .cmoEnable, .reqValid, .reqReady,
    .req, .lineAddr, .lineDirty, .pendAlloc, .pendCacheable, .blockAlloc,
    .wbValid, .wbReady, .wb, .wbDone, .invValid, .invReady, .invDone,
    .arValid, .arReady, .ar, .rValid, .rReady, .rResp, .rLast, .doneValid,
    .doneResp, .doneLocal, .hoStep, .hoPhase, .coherentOk, .agentOk);
  cmis_ic_model ic (.sys_clk, .nrst, .slow, .arValid, .arReady, .rValid,
    .rReady, .rResp, .rLast, .wbValid, .wbReady, .wbDone, .invValid,
    .invReady, .invDone);

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask : chk

  task automatic results;
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // one operation with pending traffic held off for a few cycles
  task automatic run_op(input cmis_op_t op, input logic [1:0] dom,
                        input logic [1:0] sh, input logic [3:0] snp,
                        input logic dirty);
    int nw, ni, na, n;
    nw = 0; ni = 0; na = 0;
    @(posedge sys_clk);
    req <= '{32'h0000_5a7f, op, 1'h1, dom, 1'h0};
    reqValid <= 1'h1;
    lineDirty <= dirty;
    pendAlloc <= 1'h1;
    pendCacheable <= 1'h1;
    for (n = 0; n < 90 && doneValid !== 1'h1; n++) begin
      @(negedge sys_clk);
      if (wbValid && wbReady) begin
        nw++;
        chk(wb.evict, op == CMIS_OP_CLEAN_DROP);
        chk(wb.addr, 32'h5a7f & `CMIS_LINE_MASK);
      end
      if (invValid && invReady) ni++;
      if (arValid && arReady) begin
        na++;
        chk(ar.readSnoopType, snp);
        chk(ar.shareabilityAttr, sh);
        chk(ar.cacheabilityAttr, `CMIS_CACHE_WB_ALLOC);
        chk(ar.addr, 32'h5a7f & `CMIS_LINE_MASK);
      end
      @(posedge sys_clk);
      // drop the request at the edge that takes it
      if (reqValid && reqReady) reqValid <= 1'h0;
      if (n == 4) begin
        pendAlloc <= 1'h0;
        pendCacheable <= 1'h0;
      end
    end
    reqValid <= 1'h0;
    chk(doneValid, 1'h1);
    chk(nw, dirty && op != CMIS_OP_DROP_NOWRITE);
    chk(ni, op != CMIS_OP_CLEAN_KEEP);
    chk(na, cmoEnable);
    chk(doneLocal, !cmoEnable);
    chk(doneResp, 2'h0);
    chk(lineAddr, 32'h5a7f & `CMIS_LINE_MASK);
  endtask : run_op

  // walk the handover phases and the grants in each
  task automatic handover;
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk);
      chk(hoPhase, 5'h1 << i);
      chk(coherentOk, i == 0 || i == 4);
      chk(agentOk, i == 2);
      chk(reqReady, i == 0 || i == 4);
      @(posedge sys_clk);
      hoStep <= 1'h1;
      @(posedge sys_clk);
      hoStep <= 1'h0;
      // clean phase must refuse a drop, invalidate phase a keep
      req.op <= (i == 0) ? CMIS_OP_DROP_NOWRITE : CMIS_OP_CLEAN_KEEP;
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    chk(hoPhase, 5'h01);
  endtask : handover

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard: no run needs anywhere near this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    {nrst, reqValid, lineDirty, pendAlloc, pendCacheable, hoStep} = '0;
    {slow, req} = '0;
    cmoEnable = 1'h1;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (6) @(posedge sys_clk);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      run_op(CMIS_OP_CLEAN_KEEP, `CMIS_DOM_SYSTEM, `CMIS_DOM_OUTER,
             `CMIS_SNP_CLEAN_KEEP, 1'h1);
      run_op(CMIS_OP_CLEAN_DROP, `CMIS_DOM_INNER, `CMIS_DOM_INNER,
             `CMIS_SNP_CLEAN_DROP, 1'h1);
      run_op(CMIS_OP_DROP_NOWRITE, `CMIS_DOM_NONSH, `CMIS_DOM_NONSH,
             `CMIS_SNP_DROP_NOWRITE, 1'h1);
    end
    run_op(CMIS_OP_CLEAN_KEEP, `CMIS_DOM_OUTER, `CMIS_DOM_OUTER,
           `CMIS_SNP_CLEAN_KEEP, 1'h0);
    cmoEnable <= 1'h0;
    repeat (6) @(posedge sys_clk);
    run_op(CMIS_OP_CLEAN_DROP, `CMIS_DOM_OUTER, `CMIS_DOM_OUTER,
           `CMIS_SNP_CLEAN_DROP, 1'h0);
    handover();
    results();
  end
endmodule : tb_cache_maintenance_issue_sequencer
`default_nettype wire
